/* File: hw/aip_gain_update.sv */
// Purpose: Applies the written gain code either at once or at zero cross.
// Assumes: i_zero_cross is a one-cycle indication from the analogue path.
// Notes:   The applied code comes from a register.

`timescale 1ns/100ps

module aip_gain_update
   import aip_pkg::*;
#(
   parameter int unsigned WIDTH = GAIN_W
) (
   input  wire logic             i_clk,
   input  wire logic             i_rstn,
   input  wire logic [WIDTH-1:0] i_target,
   input  wire logic             i_load,
   input  wire logic             i_zc_enable,
   input  wire logic             i_zero_cross,
   output logic      [WIDTH-1:0] o_gain,
   output logic                  o_pending
);

   typedef struct packed {
      logic [WIDTH-1:0] gain;
      logic             pending;
   } aip_gu_s;

   aip_gu_s gu_reg;
   aip_gu_s gu_next;

   if (WIDTH != GAIN_W) begin : g_chk
      $error("Gain width must match the gain field.");
   end

   // --------------------------------------------------------------------
   // Update timing.
   // --------------------------------------------------------------------
   always_comb begin
      gu_next = gu_reg;
      gu_next.pending = i_load |
         (gu_reg.pending & i_zc_enable & ~i_zero_cross); // RULE18
      if (!i_zc_enable) begin
         gu_next.gain = i_target; // RULE7
      end else if (gu_reg.pending && i_zero_cross) begin
         gu_next.gain = i_target; // RULE18
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         gu_reg <= '{gain: GAIN_ZERO_DB, pending: 1'b0};
      end else begin
         gu_reg <= gu_next;
      end
   end

   assign o_gain    = gu_reg.gain;
   assign o_pending = gu_reg.pending;

   // --------------------------------------------------------------------
   // Checks.
   // --------------------------------------------------------------------
   property p_immediate;
      @(posedge i_clk) disable iff (!i_rstn)
      !i_zc_enable |=> o_gain == $past(i_target);
   endproperty
   a_immediate: assert property (p_immediate) // RULE7
      else $error("Gain not applied at once with zero cross off.");

   property p_deferred_hold;
      @(posedge i_clk) disable iff (!i_rstn)
      (i_zc_enable && !i_zero_cross) |=> $stable(o_gain);
   endproperty
   a_deferred_hold: assert property (p_deferred_hold) // RULE18
      else $error("Gain changed before a zero crossing.");

endmodule // aip_gain_update

/* File: hw/aip_input_path.sv */
// Purpose: Control registers for the analogue input amplifier path.
// Assumes: Serial pins are synchronous to i_clk and slow against it.
// Notes:   Overview of operation and checks follow.
//
// Overview of operation
// (RULE1) Bit 0 selects positive terminal source.
// (RULE2) Bit 1 connects negative mic pin.
// (RULE3) Bit 2 connects aux output to amplifier.
// (RULE4) Power two bit 2 enables amplifier.
// (RULE5) Gain code maps -12dB plus 0.75dB steps.
// (RULE6) One gain serves all amplifier inputs.
// (RULE7) Bit 7 defers gain to zero cross.
// (RULE8) Bit 6 mutes and detaches amplifier.
// (RULE9) Level bit 8 picks automatic gain source.
// (RULE10) Host leaves gain field alone under automatic.
// (RULE11) Power one bit 6 enables aux circuit.
// (RULE12) Input bit 3 selects aux mixer mode.
// (RULE13) Host sets pseudo differential selects together.
// (RULE14) Host sets single ended selects together.
// (RULE15) Mode pin high three wire, low two.
// (RULE16) Two wire target answers only its address.
// (RULE17) Fields reset to defaults, hold until written.
// (RULE18) Deferred gain waits for zero cross.

`timescale 1ns/100ps

module aip_input_path
   import aip_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = TWO_WIRE_ADDR
) (
   input  wire logic               i_clk,
   input  wire logic               i_rstn,
   input  wire logic               i_mode,
   input  wire logic               i_sclk,
   input  wire logic               i_sdin,
   input  wire logic               i_csb,
   output logic                    o_sdin_out,
   output logic                    o_sdin_oe,
   input  wire logic               i_zero_cross,
   input  wire logic [5:0]         i_alc_gain,
   output aip_route_s              o_route,
   output logic                    o_aux_bypass_switch,
   output logic                    o_aux_circuit_enable,
   output logic                    o_input_amp_enable,
   output logic                    o_input_amp_mute,
   output logic                    o_auto_level_select,
   output logic [5:0]              o_input_amp_gain,
   output logic signed [8:0]       o_gain_qdb,
   output logic                    o_gain_pending
);

   aip_state_s s_reg;
   aip_state_s s_next;
   logic [5:0] applied_gain;
   logic       scl_rise;
   logic       scl_fall;
   logic       tw_start;
   logic       tw_stop;
   logic       vol_load;

   if (DEV_ADDR == 7'h00) begin : g_chk
      $error("Two wire address zero is the general call address.");
   end

   // --------------------------------------------------------------------
   // Pin events.
   // --------------------------------------------------------------------
   assign scl_rise = i_sclk & ~s_reg.scl_prev;
   assign scl_fall = ~i_sclk & s_reg.scl_prev;
   assign tw_start = i_sclk & s_reg.scl_prev & s_reg.sda_prev & ~i_sdin;
   assign tw_stop  = i_sclk & s_reg.scl_prev & ~s_reg.sda_prev & i_sdin;
   assign vol_load = s_reg.wr_pulse && (s_reg.wr_addr == ADDR_VOL);

   // --------------------------------------------------------------------
   // Gain timing.
   // --------------------------------------------------------------------
   aip_gain_update #(
      .WIDTH        (GAIN_W)
   ) u_gain (
      .i_clk        (i_clk),
      .i_rstn       (i_rstn),
      .i_target     (s_reg.regs.vol[GAIN_MSB:0]),
      .i_load       (vol_load),
      .i_zc_enable  (s_reg.regs.vol[BIT_GAIN_ZC]),
      .i_zero_cross (i_zero_cross),
      .o_gain       (applied_gain),
      .o_pending    (o_gain_pending)
   );

   // --------------------------------------------------------------------
   // Next state.
   // --------------------------------------------------------------------
   always_comb begin
      s_next          = s_reg;
      s_next.scl_prev = i_sclk;
      s_next.sda_prev = i_sdin;
      s_next.csb_prev = i_csb;
      s_next.wr_pulse = 1'b0;

      if (i_mode) begin
         // Three wire: shift while select is low, write on its rise if at least 16 bits came in.
         s_next.tw        = TW_IDLE; // RULE15
         s_next.sda_drive = 1'b0; // RULE15
         if (!i_csb && scl_rise) begin
            s_next.shift = {s_reg.shift[14:0], i_sdin};
            if (s_reg.bit_cnt != FRAME_BITS) begin
               s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
            end
         end
         if (i_csb && !s_reg.csb_prev) begin
            s_next.bit_cnt  = 5'h00;
            s_next.wr_pulse = (s_reg.bit_cnt == FRAME_BITS);
            s_next.wr_addr  = s_reg.shift[15:9];
            s_next.wr_data  = s_reg.shift[8:0];
         end
      end else if (tw_start) begin
         s_next.tw        = TW_DEV; // RULE15
         s_next.bit_cnt   = 5'h00;
         s_next.sda_drive = 1'b0;
      end else if (tw_stop) begin
         s_next.tw        = TW_IDLE;
         s_next.sda_drive = 1'b0;
      end else begin
         unique case (s_reg.tw)
            TW_DEV, TW_HI, TW_LO: begin
               if (scl_rise) begin
                  s_next.shift   = {s_reg.shift[14:0], i_sdin};
                  s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
               end
               if (scl_fall && s_reg.bit_cnt == BYTE_BITS) begin
                  s_next.bit_cnt   = 5'h00;
                  s_next.sda_drive = 1'b1;
                  if (s_reg.tw == TW_DEV) begin
                     if (s_reg.shift[7:1] == DEV_ADDR && !s_reg.shift[0])
                     begin
                        s_next.tw = TW_ACK_DEV; // RULE16
                     end else begin
                        s_next.tw        = TW_SKIP; // RULE16
                        s_next.sda_drive = 1'b0;
                     end
                  end else if (s_reg.tw == TW_HI) begin
                     s_next.tw = TW_ACK_HI;
                  end else begin
                     s_next.tw       = TW_ACK_LO;
                     s_next.wr_pulse = 1'b1;
                     s_next.wr_addr  = s_reg.shift[15:9];
                     s_next.wr_data  = s_reg.shift[8:0];
                  end
               end
            end
            TW_ACK_DEV, TW_ACK_HI, TW_ACK_LO: begin
               if (scl_fall) begin
                  s_next.sda_drive = 1'b0;
                  if (s_reg.tw == TW_ACK_DEV) begin
                     s_next.tw = TW_HI;
                  end else if (s_reg.tw == TW_ACK_HI) begin
                     s_next.tw = TW_LO;
                  end else begin
                     s_next.tw = TW_SKIP;
                  end
               end
            end
            TW_IDLE, TW_SKIP: begin
               s_next.sda_drive = 1'b0;
            end
         endcase
      end

      // Register writes land one cycle after the write pulse.
      if (s_reg.wr_pulse) begin
         case (s_reg.wr_addr)
            ADDR_PWR_ONE: s_next.regs.pwr_one = s_reg.wr_data; // RULE17
            ADDR_PWR_TWO: s_next.regs.pwr_two = s_reg.wr_data; // RULE17
            ADDR_LVL_ONE: s_next.regs.lvl_one = s_reg.wr_data; // RULE17
            ADDR_ROUTE:   s_next.regs.route   = s_reg.wr_data; // RULE17
            ADDR_VOL:     s_next.regs.vol     = s_reg.wr_data; // RULE17
            default:      s_next.regs         = s_reg.regs;
         endcase
      end

      // One gain drives every amplifier input; source set by level bit.
      if (s_reg.regs.lvl_one[BIT_AUTO_LVL]) begin
         s_next.gain = i_alc_gain; // RULE9 RULE6
      end else begin
         s_next.gain = applied_gain; // RULE9 RULE6
      end
      s_next.qdb = gain_to_qdb(s_next.gain); // RULE5
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         s_reg <= '{
            regs: '{pwr_one: RST_PWR_ONE, pwr_two: RST_PWR_TWO,
                    lvl_one: RST_LVL_ONE, route: RST_ROUTE,
                    vol: RST_VOL},
            tw: TW_IDLE, scl_prev: 1'b1, sda_prev: 1'b1, csb_prev: 1'b1,
            shift: 16'h0000, bit_cnt: 5'h00, sda_drive: 1'b0,
            wr_pulse: 1'b0, wr_addr: 7'h00, wr_data: 9'h000,
            gain: GAIN_ZERO_DB, qdb: 9'sh000}; // RULE17
      end else begin
         s_reg <= s_next;
      end
   end

   // --------------------------------------------------------------------
   // Outputs.
   // --------------------------------------------------------------------
   assign o_sdin_out           = 1'b0;
   assign o_sdin_oe            = s_reg.sda_drive;
   assign o_route.pos_term     = s_reg.regs.route[BIT_POS_TERM]; // RULE1
   assign o_route.neg_mic      = s_reg.regs.route[BIT_NEG_MIC]; // RULE2
   assign o_route.aux_to_amp   = s_reg.regs.route[BIT_AUX_AMP]; // RULE3
   assign o_route.aux_mode     = s_reg.regs.route[BIT_AUX_MODE]; // RULE12
   assign o_aux_bypass_switch  = s_reg.regs.route[BIT_AUX_MODE]; // RULE12
   assign o_aux_circuit_enable = s_reg.regs.pwr_one[BIT_AUX_EN]; // RULE11
   assign o_input_amp_enable   = s_reg.regs.pwr_two[BIT_AMP_EN]; // RULE4
   assign o_input_amp_mute     = s_reg.regs.vol[BIT_MUTE]; // RULE8
   assign o_auto_level_select  = s_reg.regs.lvl_one[BIT_AUTO_LVL]; // RULE9
   assign o_input_amp_gain     = s_reg.gain;
   assign o_gain_qdb           = s_reg.qdb;

   // --------------------------------------------------------------------
   // Checks.
   // --------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_write(logic [6:0] a);
      s_reg.wr_pulse && s_reg.wr_addr == a;
   endsequence

   property p_reset_defaults;
      @(posedge i_clk) disable iff (1'b0)
      !i_rstn |=> (o_route == 4'b0010 && o_input_amp_mute &&
                   !o_input_amp_enable && !o_auto_level_select &&
                   !o_aux_circuit_enable && o_input_amp_gain == 6'h10);
   endproperty
   a_reset_defaults: assert property (p_reset_defaults) // RULE17
      else $error("Control fields not at defaults after reset.");

   property p_route_write;
      s_write(ADDR_ROUTE) ##1 1'b1 |->
         o_route == $past(s_reg.wr_data[3:0]) &&
         o_aux_bypass_switch == $past(s_reg.wr_data[3]);
   endproperty
   a_route_write: assert property (p_route_write) // RULE1 RULE2 RULE3
      else $error("Routing selects do not follow the written value.");

   property p_amp_enable;
      s_write(ADDR_PWR_TWO) |=> o_input_amp_enable == $past(s_reg.wr_data[2]);
   endproperty
   a_amp_enable: assert property (p_amp_enable) // RULE4
      else $error("Amplifier enable does not follow the write.");

   property p_mute;
      s_write(ADDR_VOL) |=> o_input_amp_mute == $past(s_reg.wr_data[6]);
   endproperty
   a_mute: assert property (p_mute) // RULE8
      else $error("Amplifier mute does not follow the write.");

   property p_aux_enable;
      s_write(ADDR_PWR_ONE) |=>
         o_aux_circuit_enable == $past(s_reg.wr_data[6]);
   endproperty
   a_aux_enable: assert property (p_aux_enable) // RULE11
      else $error("Aux circuit enable does not follow the write.");

   property p_auto_source;
      o_auto_level_select |=> o_input_amp_gain == $past(i_alc_gain);
   endproperty
   a_auto_source: assert property (p_auto_source) // RULE9
      else $error("Automatic gain not passed to the amplifier.");

   property p_hold;
      !s_reg.wr_pulse |=> $stable(s_reg.regs);
   endproperty
   a_hold: assert property (p_hold) // RULE17
      else $error("Register changed without a write.");

   property p_three_wire_quiet;
      i_mode |=> !o_sdin_oe;
   endproperty
   a_three_wire_quiet: assert property (p_three_wire_quiet) // RULE15
      else $error("Data pin driven in three wire mode.");

   property p_ack_addr;
      ($rose(o_sdin_oe) && s_reg.tw == TW_ACK_DEV) |->
         $past(s_reg.shift[7:0]) == {DEV_ADDR, 1'b0};
   endproperty
   a_ack_addr: assert property (p_ack_addr) // RULE16
      else $error("Acknowledged a foreign two wire address.");

   property p_gain_scale;
      (o_input_amp_gain == GAIN_ZERO_DB |-> o_gain_qdb == 9'sh000) and
      (o_input_amp_gain == GAIN_TOP |-> o_gain_qdb == QDB_TOP) and
      (o_input_amp_gain == 6'h00 |-> o_gain_qdb == -QDB_OFFSET);
   endproperty
   a_gain_scale: assert property (p_gain_scale) // RULE5
      else $error("Gain code to decibel scale is wrong.");

endmodule // aip_input_path

/* File: hw/aip_pkg.sv */
// Purpose: Shared constants, types and helpers for the input path control.
// Assumes: Registers are 9 bits wide behind 7-bit register addresses.
// Notes:   Gains are also reported in quarter-decibel units.

package aip_pkg;

   // --------------------------------------------------------------------
   // Widths.
   // --------------------------------------------------------------------
   localparam int unsigned REG_AW  = 7;
   localparam int unsigned REG_DW  = 9;
   localparam int unsigned GAIN_W  = 6;
   localparam int unsigned QDB_W   = 9;

   // --------------------------------------------------------------------
   // Register addresses.
   // --------------------------------------------------------------------
   localparam logic [6:0] ADDR_PWR_ONE = 7'h01;
   localparam logic [6:0] ADDR_PWR_TWO = 7'h02;
   localparam logic [6:0] ADDR_LVL_ONE = 7'h20;
   localparam logic [6:0] ADDR_ROUTE   = 7'h2c;
   localparam logic [6:0] ADDR_VOL     = 7'h2d;

   // --------------------------------------------------------------------
   // Field positions.
   // --------------------------------------------------------------------
   localparam int unsigned BIT_POS_TERM = 0;
   localparam int unsigned BIT_NEG_MIC  = 1;
   localparam int unsigned BIT_AUX_AMP  = 2;
   localparam int unsigned BIT_AUX_MODE = 3;
   localparam int unsigned BIT_AMP_EN   = 2;
   localparam int unsigned BIT_MUTE     = 6;
   localparam int unsigned BIT_GAIN_ZC  = 7;
   localparam int unsigned BIT_AUTO_LVL = 8;
   localparam int unsigned BIT_AUX_EN   = 6;
   localparam int unsigned GAIN_MSB     = 5;

   // --------------------------------------------------------------------
   // Reset values and top gain code.
   // --------------------------------------------------------------------
   localparam logic [8:0] RST_PWR_ONE = 9'h000;
   localparam logic [8:0] RST_PWR_TWO = 9'h000;
   localparam logic [8:0] RST_LVL_ONE = 9'h000;
   localparam logic [8:0] RST_ROUTE   = 9'h002;
   localparam logic [8:0] RST_VOL     = 9'h050;
   localparam logic [5:0] GAIN_ZERO_DB = 6'h10;
   localparam logic [5:0] GAIN_TOP     = 6'h3f;

   // --------------------------------------------------------------------
   // Serial port and gain scale constants.
   // --------------------------------------------------------------------
   localparam logic [6:0] TWO_WIRE_ADDR = 7'h1a;
   localparam logic [4:0] BYTE_BITS     = 5'h08;
   localparam logic [4:0] FRAME_BITS    = 5'h10;
   localparam logic signed [8:0] QDB_STEP   = 9'sh003;
   localparam logic signed [8:0] QDB_OFFSET = 9'sh030;
   localparam logic signed [8:0] QDB_TOP    = 9'sh08d;

   // --------------------------------------------------------------------
   // Types.
   // --------------------------------------------------------------------
   typedef enum logic [2:0] {
      TW_IDLE, TW_DEV, TW_ACK_DEV, TW_HI, TW_ACK_HI, TW_LO, TW_ACK_LO,
      TW_SKIP
   } aip_tw_e;

   typedef struct packed {
      logic aux_mode;
      logic aux_to_amp;
      logic neg_mic;
      logic pos_term;
   } aip_route_s;

   typedef struct packed {
      logic [8:0] pwr_one;
      logic [8:0] pwr_two;
      logic [8:0] lvl_one;
      logic [8:0] route;
      logic [8:0] vol;
   } aip_regs_s;

   typedef struct packed {
      aip_regs_s          regs;
      aip_tw_e            tw;
      logic               scl_prev;
      logic               sda_prev;
      logic               csb_prev;
      logic [15:0]        shift;
      logic [4:0]         bit_cnt;
      logic               sda_drive;
      logic               wr_pulse;
      logic [6:0]         wr_addr;
      logic [8:0]         wr_data;
      logic [5:0]         gain;
      logic signed [8:0]  qdb;
   } aip_state_s;

   // Quarter-decibel gain of a gain code: 3 * code - 48.
   function automatic logic signed [8:0] gain_to_qdb(input logic [5:0] c);
      return $signed({3'b000, c}) * QDB_STEP - QDB_OFFSET;
   endfunction

endpackage

/* File: verif/audio_input_path_control_bench.sv */
// Purpose: Self-checking bench for the input path control registers.
// Assumes: Host writes only; three-wire and two-wire frames are bit-banged.
// Notes:   Serial pin levels are held two to eight clock cycles each.

`timescale 1ns/100ps

module audio_input_path_control_bench;
   import aip_pkg::*;

   // ---------------------------------------------------------------------
   // Signals and instance.
   // ---------------------------------------------------------------------
   logic              i_clk = 1'b0;
   logic              i_rstn = 1'b0;
   logic              i_mode = 1'b1;
   logic              i_sclk = 1'b1;
   logic              sda_host = 1'b1;
   logic              i_sdin;
   logic              i_csb = 1'b1;
   logic              o_sdin_out;
   logic              o_sdin_oe;
   logic              i_zero_cross = 1'b0;
   logic [5:0]        i_alc_gain = 6'h33;
   aip_route_s        o_route;
   logic              o_aux_bypass_switch;
   logic              o_aux_circuit_enable;
   logic              o_input_amp_enable;
   logic              o_input_amp_mute;
   logic              o_auto_level_select;
   logic [5:0]        o_input_amp_gain;
   logic signed [8:0] o_gain_qdb;
   logic              o_gain_pending;
   int                error_cnt = 0;
   int                cmp_count = 0;
   logic [5:0]        codes [4] = '{6'h00, 6'h10, 6'h3f, 6'h01};
   logic              ack;

   // Open-drain data line: the device pulls low while its enable is high.
   assign i_sdin = sda_host & ~(o_sdin_oe & ~o_sdin_out);

   always #5 i_clk = ~i_clk;

   aip_input_path u_aip_input_path (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_mode(i_mode), .i_sclk(i_sclk),
      .i_sdin(i_sdin), .i_csb(i_csb), .o_sdin_out(o_sdin_out),
      .o_sdin_oe(o_sdin_oe), .i_zero_cross(i_zero_cross),
      .i_alc_gain(i_alc_gain), .o_route(o_route),
      .o_aux_bypass_switch(o_aux_bypass_switch),
      .o_aux_circuit_enable(o_aux_circuit_enable),
      .o_input_amp_enable(o_input_amp_enable),
      .o_input_amp_mute(o_input_amp_mute),
      .o_auto_level_select(o_auto_level_select),
      .o_input_amp_gain(o_input_amp_gain), .o_gain_qdb(o_gain_qdb),
      .o_gain_pending(o_gain_pending)
   );

   // ---------------------------------------------------------------------
   // Tasks.
   // ---------------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [8:0] e,
                      input logic [8:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask

   task automatic stop_test();
      $display("Checks %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Three-wire frame: first n bits of {addr, data}, MSB first.
   task automatic wr3(input logic [6:0] a, input logic [8:0] d, input int n);
      logic [15:0] f;
      f = {a, d};
      i_csb = 1'b0;
      tick(4);
      for (int i = 15; i > 15 - n; i--) begin
         sda_host = f[i];
         i_sclk = 1'b0;
         tick(4);
         i_sclk = 1'b1;
         tick(4);
      end
      i_csb = 1'b1;
      sda_host = 1'b1;
      tick(8);
   endtask

   // Two-wire byte followed by the acknowledge clock.
   task automatic byte2(input logic [7:0] b, output logic a);
      for (int i = 7; i >= 0; i--) begin
         sda_host = b[i];
         tick(2);
         i_sclk = 1'b1;
         tick(4);
         i_sclk = 1'b0;
         tick(2);
      end
      sda_host = 1'b1;
      tick(2);
      i_sclk = 1'b1;
      tick(2);
      a = ~i_sdin;
      tick(2);
      i_sclk = 1'b0;
      tick(4);
   endtask

   task automatic wr2(input logic [7:0] dev, input logic [6:0] a,
                      input logic [8:0] d, output logic a0);
      logic a1;
      sda_host = 1'b0;
      tick(4);
      i_sclk = 1'b0;
      tick(4);
      byte2(dev, a0);
      byte2({a, d[8]}, a1);
      byte2(d[7:0], a1);
      sda_host = 1'b0;
      tick(2);
      i_sclk = 1'b1;
      tick(4);
      sda_host = 1'b1;
      tick(8);
   endtask

   // ---------------------------------------------------------------------
   // Sequence.
   // ---------------------------------------------------------------------
   initial begin
      repeat (30000) @(posedge i_clk);
      $display("[FAIL] run limit expected end seen hang");
      error_cnt++;
      stop_test();
   end

   initial begin
      tick(6);
      i_rstn = 1'b1;
      tick(2);
      chk("route", 9'h002, {5'h00, o_route});
      chk("mute", 9'h001, {8'h00, o_input_amp_mute});
      chk("gain", 9'h010, {3'h0, o_input_amp_gain});
      chk("amp_en", 9'h000, {8'h00, o_input_amp_enable});
      chk("aux_en", 9'h000, {8'h00, o_aux_circuit_enable});
      chk("alc", 9'h000, {8'h00, o_auto_level_select});
      chk("pend", 9'h000, {8'h00, o_gain_pending});
      wr3(ADDR_ROUTE, 9'h00d, 16);
      chk("route", 9'h00d, {5'h00, o_route});
      chk("bypass", 9'h001, {8'h00, o_aux_bypass_switch});
      wr3(ADDR_PWR_TWO, 9'h004, 16);
      chk("amp_en", 9'h001, {8'h00, o_input_amp_enable});
      wr3(ADDR_PWR_ONE, 9'h040, 16);
      chk("aux_en", 9'h001, {8'h00, o_aux_circuit_enable});
      wr3(ADDR_PWR_ONE, 9'h1bf, 16);
      chk("aux_en", 9'h000, {8'h00, o_aux_circuit_enable});
      wr3(7'h2e, 9'h1ff, 16);
      wr3(ADDR_ROUTE, 9'h000, 8);
      chk("route", 9'h00d, {5'h00, o_route});
      chk("amp_en", 9'h001, {8'h00, o_input_amp_enable});
      foreach (codes[i]) begin
         wr3(ADDR_VOL, {3'h0, codes[i]}, 16);
         chk("gain", {3'h0, codes[i]}, {3'h0, o_input_amp_gain});
         chk("qdb", 9'(3 * int'(codes[i]) - 48), o_gain_qdb);
         chk("mute", 9'h000, {8'h00, o_input_amp_mute});
         chk("pend", 9'h000, {8'h00, o_gain_pending});
      end
      wr3(ADDR_VOL, 9'h0aa, 16);
      chk("pend", 9'h001, {8'h00, o_gain_pending});
      tick(5);
      chk("gain", 9'h001, {3'h0, o_input_amp_gain});
      i_zero_cross = 1'b1;
      tick(1);
      i_zero_cross = 1'b0;
      tick(4);
      chk("gain", 9'h02a, {3'h0, o_input_amp_gain});
      chk("pend", 9'h000, {8'h00, o_gain_pending});
      wr3(ADDR_LVL_ONE, 9'h100, 16);
      chk("alc", 9'h001, {8'h00, o_auto_level_select});
      chk("gain", 9'h033, {3'h0, o_input_amp_gain});
      i_alc_gain = 6'h05;
      tick(4);
      chk("gain", 9'h005, {3'h0, o_input_amp_gain});
      i_mode = 1'b0;
      tick(4);
      wr2({TWO_WIRE_ADDR, 1'b0}, ADDR_ROUTE, 9'h00a, ack);
      chk("ack", 9'h001, {8'h00, ack});
      chk("route", 9'h00a, {5'h00, o_route});
      wr2({7'h1b, 1'b0}, ADDR_ROUTE, 9'h004, ack);
      chk("ack", 9'h000, {8'h00, ack});
      chk("route", 9'h00a, {5'h00, o_route});
      wr2({TWO_WIRE_ADDR, 1'b1}, ADDR_ROUTE, 9'h004, ack);
      chk("ack", 9'h000, {8'h00, ack});
      chk("route", 9'h00a, {5'h00, o_route});
      i_rstn = 1'b0;
      tick(6);
      i_rstn = 1'b1;
      tick(2);
      chk("route", 9'h002, {5'h00, o_route});
      chk("gain", 9'h010, {3'h0, o_input_amp_gain});
      stop_test();
   end

endmodule // audio_input_path_control_bench
